// [core/cls_defs.vh]
// constants for the stop and speed-pulse configuration block
`ifndef CLS_DEFS_VH
`define CLS_DEFS_VH
// register indices; byte address is four times the index
`define CLS_IDX_LOOP1 8'h88
`define CLS_IDX_LOOP2 8'h8a
`define CLS_IDX_CEIL 8'h90
`define CLS_IDX_STAT 8'h92
// output and enable register fields
`define CLS_DIV_HI 11
`define CLS_DIV_LO 8
`define CLS_GATE_BIT 7
`define CLS_EMF_HI 6
`define CLS_EMF_LO 4
`define CLS_SURGE_BIT 3
`define CLS_DTC_BIT 2
`define CLS_VLOFF_BIT 1
`define CLS_RECIRC_BIT 0
`define CLS_LOOP1_W 12
// stop and motor parameter register fields
`define CLS_RSV_BIT 31
`define CLS_STOP_HI 30
`define CLS_STOP_LO 28
`define CLS_HOLD_HI 27
`define CLS_HOLD_LO 24
`define CLS_SPIN_HI 23
`define CLS_SPIN_LO 20
`define CLS_BRK_HI 19
`define CLS_BRK_LO 16
`define CLS_RES_HI 15
`define CLS_RES_LO 8
`define CLS_IND_HI 7
`define CLS_IND_LO 0
// speed ceiling register
`define CLS_CEIL_W 14
`define CLS_CEIL_RST 14'h3fff
// stop method codes
`define CLS_STOP_HIZ 3'h0
`define CLS_STOP_LSB 3'h2
`define CLS_STOP_HSB 3'h3
`define CLS_STOP_SPIN 3'h4
`define CLS_STOP_ALIGN 3'h5
// bridge command codes driven out
`define CLS_BR_DRIVE 3'h0
`define CLS_BR_HIZ 3'h1
`define CLS_BR_LSB 3'h2
`define CLS_BR_HSB 3'h3
`define CLS_BR_ALIGN 3'h4
`define CLS_BR_SPIN 3'h5
// timing
`define CLS_CLK_HZ 50000000
`define CLS_MS_PER_S 1000
`define CLS_PERMILLE 10'd1000
`endif

// [core/cls_pulse_div.v]
// speed-pulse frequency divider: toggles its output every n input edges
`timescale 1ns/10ps
module cls_pulse_div #(
  parameter DW = 4
) (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire pulse_in, // raw speed pulse, same clock domain
  input wire [DW-1:0] divide_by, // divider code, 0 and 1 both divide by one
  output reg pulse_out // divided square wave
);
  reg pulse_d_r;
  reg [DW-1:0] edge_cnt_r;
  wire in_edge;
  wire [DW-1:0] limit;

  assign in_edge = pulse_in ^ pulse_d_r;
  // code 0 is treated as one so the counter never wraps through zero
  assign limit = (divide_by == {DW{1'b0}}) ? {{(DW-1){1'b0}}, 1'b1} : divide_by;

  // counting both edges keeps a 50 % duty cycle at every ratio
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_d_r <= 1'b0;
      edge_cnt_r <= {DW{1'b0}};
      pulse_out <= 1'b0;
    end else begin
      pulse_d_r <= pulse_in;
      if (in_edge) begin
        if (edge_cnt_r + {{(DW-1){1'b0}}, 1'b1} >= limit) begin
          edge_cnt_r <= {DW{1'b0}};
          pulse_out <= ~pulse_out;
        end else begin
          edge_cnt_r <= edge_cnt_r + {{(DW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // cls_pulse_div

// [core/cls_stop_ctrl.v]
// stop sequencing, speed-pulse output and motor parameter registers over apb
// Function
// - speed pulse divided by 4-bit code; codes 0 and 1 divide by one.
// - gating bit 0 keeps pulse while driven; 1 keeps it until emf low.
// - 3-bit emf level code selects 1, 2, 5, 10, 20 or 30 mV.
// - recirculation stop in open loop: bit 0 tri-states, bit 1 low-side brakes.
// - stop code: 0 hi-z, 2 low, 3 high, 4 spin-down, 5 align braking.
// - brake hold time from 4-bit code, 1 ms up to 15000 ms.
// - spin-down ends below a percentage of the speed ceiling.
// - braking and brake pin act below a second percentage threshold.
// - 8-bit phase resistance code held for the parameter tables.
// - 8-bit phase inductance code held in the low byte.
`timescale 1ns/10ps
`include "cls_defs.vh"
module cls_stop_ctrl #(
  parameter CLK_HZ = `CLS_CLK_HZ,
  parameter MS_CYC = `CLS_CLK_HZ / `CLS_MS_PER_S
) (
  input wire pclk, // system clock, 50 mhz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction, 1 = write
  input wire [9:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  input wire raw_pulse, // commutation speed pulse, same clock
  input wire [13:0] speed, // present speed, same units as ceiling
  input wire [5:0] emf_mv, // back-emf magnitude in mv
  input wire open_loop, // motor still in align or open loop
  input wire stop_req, // request to stop the motor
  input wire brake_pin, // brake pin, asynchronous
  output reg speed_pulse_output, // gated, divided speed pulse
  output reg [2:0] bridge_cmd, // bridge command code
  output reg stop_done, // motor stop sequence finished
  output reg surge_guard_enable, // surge guard enable field
  output reg velocity_loop_off, // speed loop disable field
  output reg deadtime_comp_enable, // dead-time compensation field
  output reg [7:0] phase_resistance_code, // resistance table code
  output reg [7:0] phase_inductance_code // inductance table code
);
  localparam ST_RUN = 3'h0;
  localparam ST_SPIN = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_BRAKE = 3'h3;
  localparam ST_OFF = 3'h4;
  localparam [15:0] MS_LAST = MS_CYC[15:0] - 16'h0001;

  reg [`CLS_LOOP1_W-1:0] loop1_r;
  reg stop_rsv_r;
  reg [2:0] stop_method_r;
  reg [3:0] stop_hold_time_r;
  reg [3:0] spindown_level_r;
  reg [3:0] brake_level_r;
  reg [`CLS_CEIL_W-1:0] ceil_r;
  reg brk_meta_r;
  reg brk_sync_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] bridge_nxt;
  reg [2:0] brake_kind_r;
  reg [2:0] brake_kind_nxt;
  reg [15:0] pre_r;
  reg [13:0] ms_r;
  reg [13:0] hold_ms;
  reg [4:0] emf_lvl;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire [3:0] pulse_out_divider;
  wire pulse_out_gating;
  wire [2:0] pulse_out_emf_level;
  wire low_rate_recirc_hold;
  wire div_pulse;
  wire acc;
  wire [23:0] speed_scaled;
  wire [23:0] spin_lim;
  wire [23:0] brk_lim;
  wire below_spin;
  wire below_brk;
  wire driven;
  wire hold_done;
  assign pulse_out_divider = loop1_r[`CLS_DIV_HI:`CLS_DIV_LO];
  assign pulse_out_gating = loop1_r[`CLS_GATE_BIT];
  assign pulse_out_emf_level = loop1_r[`CLS_EMF_HI:`CLS_EMF_LO];
  assign low_rate_recirc_hold = loop1_r[`CLS_RECIRC_BIT];

  // percentage code to per mille of the speed ceiling
  function [9:0] permille;
    input [3:0] code;
    begin
      case (code)
        4'h0: permille = `CLS_PERMILLE;
        4'h1: permille = 10'd900;
        4'h2: permille = 10'd800;
        4'h3: permille = 10'd700;
        4'h4: permille = 10'd600;
        4'h5: permille = 10'd500;
        4'h6: permille = 10'd450;
        4'h7: permille = 10'd400;
        4'h8: permille = 10'd350;
        4'h9: permille = 10'd300;
        4'ha: permille = 10'd250;
        4'hb: permille = 10'd200;
        4'hc: permille = 10'd150;
        4'hd: permille = 10'd100;
        4'he: permille = 10'd50;
        default: permille = 10'd25;
      endcase
    end
  endfunction

  // compare speed*1000 against ceiling*permille, so no divider is needed
  assign speed_scaled = speed * `CLS_PERMILLE;
  assign spin_lim = ceil_r * permille(spindown_level_r);
  assign brk_lim = ceil_r * permille(brake_level_r);
  assign below_spin = speed_scaled < spin_lim;
  assign below_brk = speed_scaled < brk_lim;

  // brake hold time in ms
  always @* begin
    case (stop_hold_time_r)
      4'h5: hold_ms = 14'd5;
      4'h6: hold_ms = 14'd10;
      4'h7: hold_ms = 14'd50;
      4'h8: hold_ms = 14'd100;
      4'h9: hold_ms = 14'd250;
      4'ha: hold_ms = 14'd500;
      4'hb: hold_ms = 14'd1000;
      4'hc: hold_ms = 14'd2500;
      4'hd: hold_ms = 14'd5000;
      4'he: hold_ms = 14'd15000;
      default: hold_ms = 14'd1;
    endcase
  end

  // emf level in mv; reserved codes fall back to the highest level
  always @* begin
    case (pulse_out_emf_level)
      3'h0: emf_lvl = 5'd1;
      3'h1: emf_lvl = 5'd2;
      3'h2: emf_lvl = 5'd5;
      3'h3: emf_lvl = 5'd10;
      3'h4: emf_lvl = 5'd20;
      default: emf_lvl = 5'd30;
    endcase
  end

  // apb: one wait state, so every output here is a flop
  assign acc = psel & penable & ~pready;
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      {`CLS_IDX_LOOP1, 2'b00}: rd_mux = {{(32-`CLS_LOOP1_W){1'b0}}, loop1_r};
      {`CLS_IDX_LOOP2, 2'b00}: rd_mux = {stop_rsv_r, stop_method_r, stop_hold_time_r,
        spindown_level_r, brake_level_r, phase_resistance_code, phase_inductance_code};
      {`CLS_IDX_CEIL, 2'b00}: rd_mux = {{(32-`CLS_CEIL_W){1'b0}}, ceil_r};
      {`CLS_IDX_STAT, 2'b00}: rd_mux = {23'h00_0000, stop_done, brk_sync_r,
        speed_pulse_output, state_r, bridge_cmd};
      default: rd_hit = 1'b0;
    endcase
  end

  // register writes and bus answer; reset codes are zero for a known start, except the speed ceiling, which resets to 3fff
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      loop1_r <= {`CLS_LOOP1_W{1'b0}};
      stop_rsv_r <= 1'b0;
      stop_method_r <= `CLS_STOP_HIZ;
      stop_hold_time_r <= 4'h0;
      spindown_level_r <= 4'h0;
      brake_level_r <= 4'h0;
      phase_resistance_code <= 8'h00;
      phase_inductance_code <= 8'h00;
      ceil_r <= `CLS_CEIL_RST;
    end else begin
      pready <= acc;
      pslverr <= acc & ~rd_hit;
      prdata <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
      if (psel & penable & pready & pwrite) begin // lands on the completing edge
        case (paddr)
          {`CLS_IDX_LOOP1, 2'b00}: loop1_r <= pwdata[`CLS_LOOP1_W-1:0];
          {`CLS_IDX_LOOP2, 2'b00}: begin
            stop_rsv_r <= pwdata[`CLS_RSV_BIT];
            stop_method_r <= pwdata[`CLS_STOP_HI:`CLS_STOP_LO];
            stop_hold_time_r <= pwdata[`CLS_HOLD_HI:`CLS_HOLD_LO];
            spindown_level_r <= pwdata[`CLS_SPIN_HI:`CLS_SPIN_LO];
            brake_level_r <= pwdata[`CLS_BRK_HI:`CLS_BRK_LO];
            phase_resistance_code <= pwdata[`CLS_RES_HI:`CLS_RES_LO];
            phase_inductance_code <= pwdata[`CLS_IND_HI:`CLS_IND_LO];
          end
          {`CLS_IDX_CEIL, 2'b00}: ceil_r <= pwdata[`CLS_CEIL_W-1:0];
          default: ceil_r <= ceil_r;
        endcase
      end
    end
  end

  // enable fields go out as flops straight from the register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      surge_guard_enable <= 1'b0;
      velocity_loop_off <= 1'b0;
      deadtime_comp_enable <= 1'b0;
    end else begin
      surge_guard_enable <= loop1_r[`CLS_SURGE_BIT];
      velocity_loop_off <= loop1_r[`CLS_VLOFF_BIT];
      deadtime_comp_enable <= loop1_r[`CLS_DTC_BIT];
    end
  end

  // brake pin comes from outside the clock domain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_meta_r <= 1'b0;
      brk_sync_r <= 1'b0;
    end else begin
      brk_meta_r <= brake_pin;
      brk_sync_r <= brk_meta_r;
    end
  end

  // stop sequencer; a dropped stop request always returns to drive
  assign hold_done = (ms_r >= hold_ms) && (pre_r == MS_LAST);
  always @* begin
    state_nxt = state_r;
    brake_kind_nxt = brake_kind_r;
    bridge_nxt = `CLS_BR_HIZ;
    case (state_r)
      ST_RUN: begin
        bridge_nxt = (brk_sync_r & below_brk) ? `CLS_BR_LSB : `CLS_BR_DRIVE;
        if (stop_req) begin
          case (stop_method_r)
            `CLS_STOP_SPIN: state_nxt = ST_SPIN;
            `CLS_STOP_LSB: begin
              state_nxt = ST_WAIT;
              brake_kind_nxt = `CLS_BR_LSB;
            end
            `CLS_STOP_HSB: begin
              state_nxt = ST_WAIT;
              brake_kind_nxt = `CLS_BR_HSB;
            end
            `CLS_STOP_ALIGN: begin
              state_nxt = ST_WAIT;
              brake_kind_nxt = `CLS_BR_ALIGN;
            end
            default: state_nxt = ST_OFF; // hi-z and undefined codes coast
          endcase
          // braking not yet safe before closed loop: hold choice decides
          if (open_loop && state_nxt == ST_WAIT) begin
            if (low_rate_recirc_hold) begin
              brake_kind_nxt = `CLS_BR_LSB;
            end else begin
              state_nxt = ST_OFF;
            end
          end
        end
      end
      ST_SPIN: begin
        bridge_nxt = `CLS_BR_SPIN;
        if (below_spin) begin
          state_nxt = ST_OFF;
        end
      end
      ST_WAIT: begin
        if (below_brk) begin
          state_nxt = ST_BRAKE;
          bridge_nxt = brake_kind_r;
        end
      end
      ST_BRAKE: begin
        bridge_nxt = brake_kind_r;
        if (hold_done) begin
          state_nxt = ST_OFF;
        end
      end
      ST_OFF: bridge_nxt = `CLS_BR_HIZ;
      default: state_nxt = ST_OFF;
    endcase
    if (!stop_req && state_r != ST_RUN) begin
      state_nxt = ST_RUN;
      bridge_nxt = `CLS_BR_DRIVE;
    end else if (state_nxt == ST_OFF) begin
      bridge_nxt = `CLS_BR_HIZ;
    end
  end

  // state, bridge command and millisecond timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      brake_kind_r <= `CLS_BR_LSB;
      bridge_cmd <= `CLS_BR_DRIVE;
      stop_done <= 1'b0;
      pre_r <= 16'h0000;
      ms_r <= 14'h0000;
    end else begin
      state_r <= state_nxt;
      brake_kind_r <= brake_kind_nxt;
      bridge_cmd <= bridge_nxt;
      stop_done <= (state_nxt == ST_OFF);
      if (state_r != ST_BRAKE) begin
        pre_r <= 16'h0000;
        ms_r <= 14'h0000;
      end else if (pre_r == MS_LAST) begin
        pre_r <= 16'h0000;
        ms_r <= ms_r + 14'h0001;
      end else begin
        pre_r <= pre_r + 16'h0001;
      end
    end
  end

  cls_pulse_div #(
    .DW(4)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .pulse_in(raw_pulse),
    .divide_by(pulse_out_divider),
    .pulse_out(div_pulse)
  );

  // pulse gating: driven, or after stop while emf stays at or above the level
  assign driven = (state_r == ST_RUN) || (state_r == ST_SPIN);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_pulse_output <= 1'b0;
    end else if (driven || (pulse_out_gating && ({1'b0, emf_mv} >= {2'b00, emf_lvl}))) begin
      speed_pulse_output <= div_pulse;
    end else begin
      speed_pulse_output <= 1'b0;
    end
  end
endmodule // cls_stop_ctrl

// [tb/cls_stop_checker.sv]
// port assertions for the stop and speed-pulse block
`timescale 1ns/10ps
`include "cls_defs.vh"
module cls_stop_checker (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire [31:0] prdata, // apb read data
  input wire pready, // apb ready
  input wire pslverr, // apb error
  input wire raw_pulse, // raw speed pulse
  input wire stop_req, // stop request
  input wire brake_pin, // brake pin
  input wire [5:0] emf_mv, // back-emf in mv
  input wire speed_pulse_output, // divided pulse
  input wire [2:0] bridge_cmd, // bridge command
  input wire stop_done // stop finished
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // an access phase taken once is answered at the next edge
  sequence s_take;
    psel && penable && !pready;
  endsequence
  // a long stretch in drive, so gating changes have settled
  sequence s_run;
    (bridge_cmd == `CLS_BR_DRIVE)[*6];
  endsequence
  // coasting with no emf left at all
  sequence s_dead;
    (bridge_cmd == `CLS_BR_HIZ && emf_mv == 6'h00)[*4];
  endsequence
  a_ready_late: assert property (s_take |=> pready) else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  a_done_hiz: assert property (stop_done |-> bridge_cmd == `CLS_BR_HIZ)
    else $error("stopped but bridge driven");
  a_run_drive: assert property ((!stop_req && !brake_pin)[*4] |-> bridge_cmd == `CLS_BR_DRIVE)
    else $error("not driving without a stop");
  a_done_cause: assert property ($rose(stop_done) |-> $past(stop_req))
    else $error("stop without request");
  a_gate_dead: assert property (s_dead |-> !speed_pulse_output)
    else $error("pulse out with no emf");
  a_pulse_src: assert property (s_run ##0 $changed(speed_pulse_output)
    |-> $past(raw_pulse, 2) != $past(raw_pulse, 3))
    else $error("pulse out moved without input edge");
endmodule // cls_stop_checker

// [tb/cls_motor_model.sv]
// behavioural motor: speed, back-emf and raw speed pulse
`timescale 1ns/10ps
`include "cls_defs.vh"
module cls_motor_model (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire [2:0] bridge_cmd, // bridge command from the block
  output reg raw_pulse, // toggles every 4 cycles while turning
  output reg [13:0] speed, // present speed
  output wire [5:0] emf_mv // back-emf, speed over 16
);
  reg [1:0] ph_r;
  // speed stays below 1024, so the emf never saturates
  assign emf_mv = speed[9:4];
  // spins up while driven, coasts down slowly otherwise so thresholds take time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed <= 14'h0;
      raw_pulse <= 1'b0;
      ph_r <= 2'h0;
    end else begin
      if (bridge_cmd == `CLS_BR_DRIVE)
        speed <= (speed < 14'd996) ? speed + 14'd4 : 14'd1000;
      else if (speed != 14'h0)
        speed <= speed - 14'd1;
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3 && speed != 14'h0)
        raw_pulse <= ~raw_pulse;
    end
  end
endmodule // cls_motor_model

// [tb/cls_stop_ctrl_tb.sv]
// testbench for the stop and speed-pulse block
`timescale 1ns/10ps
`include "cls_defs.vh"
module cls_stop_ctrl_tb;
  localparam [9:0] A1 = {`CLS_IDX_LOOP1, 2'b00};
  localparam [9:0] A2 = {`CLS_IDX_LOOP2, 2'b00};
  localparam [9:0] AC = {`CLS_IDX_CEIL, 2'b00};
  reg pclk, presetn, psel, penable, pwrite, open_loop, stop_req, brake_pin, e;
  reg [9:0] paddr;
  reg [31:0] pwdata, q;
  wire [31:0] prdata;
  wire pready, pslverr, raw_pulse, speed_pulse_output, stop_done;
  wire surge_guard_enable, velocity_loop_off, deadtime_comp_enable;
  wire [13:0] speed;
  wire [5:0] emf_mv;
  wire [2:0] bridge_cmd;
  wire [7:0] phase_resistance_code, phase_inductance_code;
  integer fails, num_checks;
  // short millisecond so hold times fit the run
  cls_stop_ctrl #(.MS_CYC(10)) i_cls_stop_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .raw_pulse(raw_pulse), .speed(speed), .emf_mv(emf_mv),
    .open_loop(open_loop), .stop_req(stop_req), .brake_pin(brake_pin),
    .speed_pulse_output(speed_pulse_output), .bridge_cmd(bridge_cmd), .stop_done(stop_done),
    .surge_guard_enable(surge_guard_enable), .velocity_loop_off(velocity_loop_off),
    .deadtime_comp_enable(deadtime_comp_enable), .phase_resistance_code(phase_resistance_code),
    .phase_inductance_code(phase_inductance_code));
  cls_motor_model i_cls_motor_model (.pclk(pclk), .presetn(presetn), .bridge_cmd(bridge_cmd),
    .raw_pulse(raw_pulse), .speed(speed), .emf_mv(emf_mv));
  // 50 mhz clock
  always #10 pclk = ~pclk;
  task wrap_up;
    begin
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task ck(input [32:0] g, input [32:0] x);
    begin
      num_checks = num_checks + 1;
      if (g !== x) begin
        fails = fails + 1;
        $display("MISMATCH %0t got %h want %h", $time, g, x);
      end
    end
  endtask
  // a used-up wait ends the run
  task lim(input integer n);
    if (n >= 2000) begin
      fails = fails + 1;
      $display("MISMATCH %0t wait limit used up", $time);
      wrap_up;
    end
  endtask
  // one apb transfer; an edge passes after release so the next one starts clean
  task apb(input [9:0] a, input w, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n = n + 1; end while (pready !== 1'b1 && n < 2000);
      lim(n);
      q = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task cnt(input integer c, output integer k);
    integer i;
    reg p;
    begin
      k = 0;
      p = speed_pulse_output;
      for (i = 0; i < c; i = i + 1) begin
        @(posedge pclk);
        if (speed_pulse_output !== p) k = k + 1;
        p = speed_pulse_output;
      end
    end
  endtask
  task t_regs;
    begin
      apb(A2, 1'b0, 32'h0); ck(q, 32'h0);
      apb(AC, 1'b0, 32'h0); ck(q, 32'h3fff);
      apb(A2, 1'b1, 32'h4c3a1b2c); apb(A2, 1'b0, 32'h0); ck(q, 32'h4c3a1b2c);
      ck({phase_resistance_code, phase_inductance_code}, 16'h1b2c);
      apb(A1, 1'b1, 32'he);
      @(negedge pclk); // enable copies settle one edge after the write lands
      ck({surge_guard_enable, deadtime_comp_enable, velocity_loop_off}, 3'h7);
      @(posedge pclk);
      apb(10'h3fc, 1'b0, 32'h0); ck({e, q}, 33'h100000000);
    end
  endtask
  task t_div(input [3:0] c, input integer x);
    integer k;
    begin
      apb(A1, 1'b1, {20'h0, c, 8'h0});
      repeat (20) @(posedge pclk);
      cnt(480, k);
      ck(k >= x - 1 && k <= x + 1, 1'b1);
    end
  endtask
  // hold code 5 is 5 ms, spin-down level 2.5 percent; only defined codes written
  task stop_run(input [2:0] c, input ol, input [3:0] b, input [2:0] cmd, input integer w,
    input integer lo, input integer hi);
    integer n;
    begin
      apb(A2, 1'b1, {1'b0, c, 4'h5, 4'hf, b, 16'h0});
      open_loop <= ol; stop_req <= 1'b1;
      n = 0;
      while (bridge_cmd !== cmd && n < 2000) begin @(posedge pclk); n = n + 1; end
      lim(n);
      ck(n >= w, 1'b1);
      n = 0;
      while (stop_done !== 1'b1 && n < 2000) begin @(posedge pclk); n = n + 1; end
      lim(n);
      ck(n >= lo && n <= hi, 1'b1);
      stop_req <= 1'b0; open_loop <= 1'b0;
      repeat (300) @(posedge pclk);
    end
  endtask
  task t_gate(input g);
    integer k;
    begin
      apb(A1, 1'b1, {24'h0, g, 3'h5, 4'h0});
      apb(A2, 1'b1, 32'h0);
      stop_req <= 1'b1;
      repeat (10) @(posedge pclk);
      cnt(200, k); ck(k > 0, g);
      repeat (500) @(posedge pclk);
      cnt(100, k); ck(k, 0);
      // let the motor coast to a standstill so no emf is left at all
      repeat (400) @(posedge pclk);
      cnt(20, k); ck(k, 0);
      stop_req <= 1'b0;
      repeat (300) @(posedge pclk);
    end
  endtask
  // brake pin in drive at full speed: low-side brake after two sync edges and one more
  task t_pin;
    integer n;
    begin
      apb(A2, 1'b1, 32'h0);
      brake_pin <= 1'b1;
      n = 0;
      while (bridge_cmd !== `CLS_BR_LSB && n < 2000) begin @(posedge pclk); n = n + 1; end
      lim(n);
      ck(n, 4);
      brake_pin <= 1'b0;
      repeat (300) @(posedge pclk);
    end
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    open_loop = 0; stop_req = 0; brake_pin = 0; fails = 0; num_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (300) @(posedge pclk);
    t_regs;
    t_div(4'h0, 120); t_div(4'h1, 120); t_div(4'h3, 40); t_div(4'hf, 8);
    stop_run(3'h0, 1'b0, 4'h0, `CLS_BR_HIZ, 0, 0, 3);
    stop_run(3'h2, 1'b0, 4'h0, `CLS_BR_LSB, 0, 45, 75);
    stop_run(3'h3, 1'b0, 4'h0, `CLS_BR_HSB, 0, 45, 75);
    stop_run(3'h5, 1'b0, 4'h0, `CLS_BR_ALIGN, 0, 45, 75);
    stop_run(3'h4, 1'b0, 4'h0, `CLS_BR_SPIN, 0, 500, 700);
    stop_run(3'h2, 1'b0, 4'hf, `CLS_BR_LSB, 500, 45, 75);
    apb(A1, 1'b1, 32'h0); stop_run(3'h2, 1'b1, 4'h0, `CLS_BR_HIZ, 0, 0, 3);
    apb(A1, 1'b1, 32'h1); stop_run(3'h2, 1'b1, 4'h0, `CLS_BR_LSB, 0, 45, 75);
    t_gate(1'b0); t_gate(1'b1);
    t_pin;
    wrap_up;
  end
endmodule // cls_stop_ctrl_tb
bind cls_stop_ctrl cls_stop_checker i_cls_stop_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .raw_pulse(raw_pulse), .stop_req(stop_req), .brake_pin(brake_pin), .emf_mv(emf_mv),
  .speed_pulse_output(speed_pulse_output), .bridge_cmd(bridge_cmd), .stop_done(stop_done));
